// ---- rtl/fwsr_top.sv ----
// Write-status reporting for a multi-bank NOR flash: replaces array data with
// poll/toggle status while an embedded program or erase runs.
// Assumes the embedded algorithm core runs on I_CLK and answers the array and
// sector-select lookups for O_RD_ADDR within one cycle.
`timescale 1ns/1ps
module fwsr_top #(
  parameter int ADDR_W = 24,
  parameter int BANK_W = 4
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // Flash bus pins
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic I_ADDRESS_VALID_N,
  input wire logic I_CE_N,
  input wire logic I_OE_N,
  input wire logic I_WE_N,
  output logic [15:0] O_DQ,
  output logic O_DQ_OE,
  output logic O_BUSY,
  // Embedded algorithm core events
  input wire logic I_PROG_START,
  input wire logic I_ERASE_START,
  input wire logic I_ALL_PROTECTED,
  input wire logic [ADDR_W-1:0] I_OP_ADDR,
  input wire logic [15:0] I_OP_DATA,
  input wire logic I_OP_DONE,
  input wire logic I_SUSPEND,
  input wire logic I_RESUME,
  input wire logic I_PULSE_LIMIT,
  input wire logic I_BUF_ABORT,
  input wire logic I_RESET_CMD,
  input wire logic I_ERASE_BEGUN,
  // Array lookup for the latched read address
  output logic [ADDR_W-1:0] O_RD_ADDR,
  input wire logic [15:0] I_ARRAY_DATA,
  input wire logic I_SECTOR_SEL
);

  localparam int PROT_MAX = (fwsr_pkg::PSP_CYC > fwsr_pkg::PAP_CYC) ?
                            fwsr_pkg::PSP_CYC : fwsr_pkg::PAP_CYC;
  localparam int CNT_MAX = (PROT_MAX > fwsr_pkg::ASP_CYC) ? PROT_MAX : fwsr_pkg::ASP_CYC;
  localparam int CNT_W = $clog2(CNT_MAX + 1);

  initial begin
    if (BANK_W < 1 || BANK_W >= ADDR_W) begin
      $error("fwsr_top: BANK_W must lie between 1 and ADDR_W-1");
    end
  end

  function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: BANK_W];
  endfunction

  function automatic logic [15:0] status_word(input logic poll, input logic t1,
      input logic tmo, input logic ert, input logic t2, input logic abt);
    logic [15:0] w;
    w = fwsr_pkg::WORD_ZERO;
    w[fwsr_pkg::BIT_POLL] = poll;
    w[fwsr_pkg::BIT_TGL1] = t1;
    w[fwsr_pkg::BIT_TMO] = tmo;
    w[fwsr_pkg::BIT_ERT] = ert;
    w[fwsr_pkg::BIT_TGL2] = t2;
    w[fwsr_pkg::BIT_ABT] = abt;
    return w;
  endfunction

  // Pin synchronisation; strobes reset to their idle high level
  logic [ADDR_W+3:0] pins_s;
  logic [ADDR_W-1:0] addr_s;
  logic avd_n_s, ce_n_s, oe_n_s, we_n_s;

  fwsr_sync #(
    .W(ADDR_W + 4),
    .RST_VAL({{ADDR_W{1'b0}}, 4'hF})
  ) u_sync (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_d({I_ADDR, I_ADDRESS_VALID_N, I_CE_N, I_OE_N, I_WE_N}),
    .o_q(pins_s)
  );

  assign addr_s = pins_s[ADDR_W+3:4];
  assign avd_n_s = pins_s[3];
  assign ce_n_s = pins_s[2];
  assign oe_n_s = pins_s[1];
  assign we_n_s = pins_s[0];

  // Read front end: a new read exists only at an address-valid falling edge
  logic avd_prev_q, avd_prev_d;
  logic rd_pend_q, rd_pend_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic rd_evt;

  always_comb begin
    rd_evt = avd_prev_q & ~avd_n_s & ~ce_n_s & we_n_s;
    avd_prev_d = avd_n_s;
    rd_pend_d = rd_evt;
    rd_addr_d = rd_evt ? addr_s : rd_addr_q;
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      avd_prev_q <= 1'b1;
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      avd_prev_q <= avd_prev_d;
      rd_pend_q <= rd_pend_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  // Operation state
  fwsr_pkg::fwsr_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] prog_addr_q, prog_addr_d;
  logic prog_d7_q, prog_d7_d;
  logic [BANK_W-1:0] erase_bank_q, erase_bank_d;
  logic erase_op_q, erase_op_d;
  logic tmo_q, tmo_d;
  logic abt_q, abt_d;
  logic cnt_end;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    prog_addr_d = prog_addr_q;
    prog_d7_d = prog_d7_q;
    erase_bank_d = erase_bank_q;
    erase_op_d = erase_op_q;
    tmo_d = tmo_q;
    abt_d = abt_q;
    cnt_end = (state_q == fwsr_pkg::ST_PROT_PROG) ? (cnt_q == CNT_W'(PROT_MAX - 1)) :
              (cnt_q == CNT_W'(fwsr_pkg::ASP_CYC - 1));
    if (I_RESET_CMD) begin
      // Reset command leaves a failed state for ST_READ, even after a program in erase suspend; ST_SUSP is kept
      state_d = erase_op_q && state_q == fwsr_pkg::ST_FAIL ? fwsr_pkg::ST_READ : state_q;
      if (state_q == fwsr_pkg::ST_FAIL) begin
        state_d = fwsr_pkg::ST_READ;
      end
      tmo_d = 1'b0;
      abt_d = 1'b0;
    end else begin
      unique case (state_q)
        fwsr_pkg::ST_READ, fwsr_pkg::ST_SUSP: begin
          if (I_PROG_START) begin
            // Status takes over in the cycle after the final write strobe
            prog_addr_d = I_OP_ADDR;
            prog_d7_d = I_OP_DATA[fwsr_pkg::BIT_POLL];
            cnt_d = '0;
            if (I_ALL_PROTECTED) begin
              state_d = fwsr_pkg::ST_PROT_PROG;
            end else begin
              state_d = (state_q == fwsr_pkg::ST_SUSP) ? fwsr_pkg::ST_SUSP_PROG :
                        fwsr_pkg::ST_PROG;
            end
            erase_op_d = (state_q == fwsr_pkg::ST_SUSP);
          end else if (I_ERASE_START && state_q == fwsr_pkg::ST_READ) begin
            erase_bank_d = bank_of(I_OP_ADDR);
            erase_op_d = 1'b1;
            cnt_d = '0;
            state_d = I_ALL_PROTECTED ? fwsr_pkg::ST_PROT_ERASE :
                      fwsr_pkg::ST_ERASE;
          end else if (I_RESUME && state_q == fwsr_pkg::ST_SUSP) begin
            state_d = fwsr_pkg::ST_ERASE;
          end
        end
        fwsr_pkg::ST_PROG, fwsr_pkg::ST_ERASE, fwsr_pkg::ST_SUSP_PROG: begin
          if (I_PULSE_LIMIT || I_BUF_ABORT) begin
            state_d = fwsr_pkg::ST_FAIL;
            tmo_d = I_PULSE_LIMIT;
            abt_d = I_BUF_ABORT;
            erase_op_d = (state_q == fwsr_pkg::ST_ERASE);
          end else if (I_OP_DONE) begin
            unique case (state_q)
              fwsr_pkg::ST_SUSP_PROG: state_d = fwsr_pkg::ST_SUSP;
              default: state_d = fwsr_pkg::ST_READ;
            endcase
            erase_op_d = (state_q == fwsr_pkg::ST_SUSP_PROG);
          end else if (I_SUSPEND && state_q == fwsr_pkg::ST_ERASE) begin
            state_d = fwsr_pkg::ST_SUSP;
          end
        end
        fwsr_pkg::ST_PROT_PROG, fwsr_pkg::ST_PROT_ERASE: begin
          cnt_d = cnt_q + CNT_W'(1);
          if (cnt_end) begin
            state_d = erase_op_q && state_q == fwsr_pkg::ST_PROT_PROG ?
                      fwsr_pkg::ST_SUSP : fwsr_pkg::ST_READ;
            erase_op_d = state_d == fwsr_pkg::ST_SUSP;
            cnt_d = '0;
          end
        end
        fwsr_pkg::ST_FAIL: begin
          state_d = fwsr_pkg::ST_FAIL;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_q <= fwsr_pkg::ST_READ;
      cnt_q <= '0;
      prog_addr_q <= '0;
      prog_d7_q <= 1'b0;
      erase_bank_q <= '0;
      erase_op_q <= 1'b0;
      tmo_q <= 1'b0;
      abt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      prog_addr_q <= prog_addr_d;
      prog_d7_q <= prog_d7_d;
      erase_bank_q <= erase_bank_d;
      erase_op_q <= erase_op_d;
      tmo_q <= tmo_d;
      abt_q <= abt_d;
    end
  end

  // Data path: status or array data, toggle bits, output drive
  logic tgl1_q, tgl1_d;
  logic tgl2_q, tgl2_d;
  logic [15:0] dq_q, dq_d;
  logic oe_q, oe_d;
  logic busy_q, busy_d;
  logic in_prog_bank, in_erase_bank, poll_prog;

  always_comb begin
    tgl1_d = tgl1_q;
    tgl2_d = tgl2_q;
    dq_d = dq_q;
    in_prog_bank = bank_of(rd_addr_q) == bank_of(prog_addr_q);
    in_erase_bank = bank_of(rd_addr_q) == erase_bank_q;
    // Only the programmed address (last buffered word) gives true poll status
    poll_prog = (rd_addr_q == prog_addr_q) ? ~prog_d7_q : prog_d7_q;
    oe_d = ~ce_n_s & ~oe_n_s & we_n_s;
    busy_d = state_d != fwsr_pkg::ST_READ && state_d != fwsr_pkg::ST_SUSP;
    if (rd_pend_q) begin
      dq_d = I_ARRAY_DATA;
      unique case (state_q)
        fwsr_pkg::ST_READ: dq_d = I_ARRAY_DATA;
        fwsr_pkg::ST_PROG, fwsr_pkg::ST_SUSP_PROG: begin
          if (in_prog_bank) begin
            tgl1_d = ~tgl1_q;
            dq_d = status_word(poll_prog, tgl1_q, 1'b0, 1'b0, tgl2_q, 1'b0);
          end
        end
        fwsr_pkg::ST_ERASE: begin
          if (in_erase_bank) begin
            tgl1_d = ~tgl1_q;
            tgl2_d = I_SECTOR_SEL ? ~tgl2_q : tgl2_q;
            // Protected sectors answer the same word; it need not be valid there
            dq_d = status_word(1'b0, tgl1_q, 1'b0, I_ERASE_BEGUN, tgl2_q, 1'b0);
          end
        end
        fwsr_pkg::ST_SUSP: begin
          if (in_erase_bank && I_SECTOR_SEL) begin
            tgl2_d = ~tgl2_q;
            dq_d = status_word(1'b1, tgl1_q, 1'b0, 1'b0, tgl2_q, 1'b0);
          end
          // Otherwise array data is passed through
        end
        fwsr_pkg::ST_PROT_PROG: begin
          if (in_prog_bank) begin
            tgl1_d = (cnt_q < CNT_W'(fwsr_pkg::PAP_CYC)) ? ~tgl1_q : tgl1_q;
            dq_d = status_word((cnt_q < CNT_W'(fwsr_pkg::PSP_CYC)) ? ~prog_d7_q : prog_d7_q,
                               tgl1_q, 1'b0, 1'b0, tgl2_q, 1'b0);
          end
        end
        fwsr_pkg::ST_PROT_ERASE: begin
          if (in_erase_bank) begin
            tgl1_d = ~tgl1_q;
            dq_d = status_word(1'b0, tgl1_q, 1'b0, 1'b0, tgl2_q, 1'b0);
          end
        end
        fwsr_pkg::ST_FAIL: begin
          if (erase_op_q ? in_erase_bank : in_prog_bank) begin
            tgl1_d = ~tgl1_q;
            dq_d = status_word(erase_op_q ? 1'b0 : poll_prog, tgl1_q, tmo_q, 1'b0,
                               tgl2_q, abt_q);
          end
        end
      endcase
    end
  end

  // The poll bit and lower bits share one register, so they switch together
  // on the read after completion; the early poll switch is never exercised
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      tgl1_q <= 1'b0;
      tgl2_q <= 1'b0;
      dq_q <= fwsr_pkg::WORD_ERASED;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      tgl1_q <= tgl1_d;
      tgl2_q <= tgl2_d;
      dq_q <= dq_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
    end
  end

  assign O_DQ = dq_q;
  assign O_DQ_OE = oe_q;
  assign O_BUSY = busy_q;
  assign O_RD_ADDR = rd_addr_q;

  property p_prog_start;
    @(posedge I_CLK) disable iff (I_RESET)
    (state_q == fwsr_pkg::ST_READ && I_PROG_START && !I_ALL_PROTECTED && !I_RESET_CMD)
      |=> state_q == fwsr_pkg::ST_PROG ##1 busy_q;
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("program start not seen");

  property p_poll_prog;
    @(posedge I_CLK) disable iff (I_RESET)
    (rd_pend_q && state_q == fwsr_pkg::ST_PROG && rd_addr_q == prog_addr_q)
      |=> O_DQ[fwsr_pkg::BIT_POLL] == !$past(prog_d7_q);
  endproperty
  a_poll_prog: assert property (p_poll_prog) else $error("poll bit not inverted");

  property p_poll_erase;
    @(posedge I_CLK) disable iff (I_RESET)
    (rd_pend_q && state_q == fwsr_pkg::ST_ERASE && in_erase_bank)
      |=> !O_DQ[fwsr_pkg::BIT_POLL];
  endproperty
  a_poll_erase: assert property (p_poll_erase) else $error("erase poll not zero");

  property p_poll_susp;
    @(posedge I_CLK) disable iff (I_RESET)
    (rd_pend_q && state_q == fwsr_pkg::ST_SUSP && in_erase_bank && I_SECTOR_SEL)
      |=> O_DQ[fwsr_pkg::BIT_POLL] && $stable(tgl1_q);
  endproperty
  a_poll_susp: assert property (p_poll_susp) else $error("suspend status wrong");

  property p_tgl1_flip;
    @(posedge I_CLK) disable iff (I_RESET)
    (rd_pend_q && state_q == fwsr_pkg::ST_PROG && in_prog_bank)
      |=> tgl1_q != $past(tgl1_q) && $stable(tgl2_q);
  endproperty
  a_tgl1_flip: assert property (p_tgl1_flip) else $error("toggle bits wrong in program");

  property p_susp_array;
    @(posedge I_CLK) disable iff (I_RESET)
    (rd_pend_q && state_q == fwsr_pkg::ST_SUSP && !I_SECTOR_SEL)
      |=> O_DQ == $past(I_ARRAY_DATA);
  endproperty
  a_susp_array: assert property (p_susp_array) else $error("suspend read not array");

  property p_other_bank;
    @(posedge I_CLK) disable iff (I_RESET)
    (rd_pend_q && state_q == fwsr_pkg::ST_PROG && !in_prog_bank)
      |=> O_DQ == $past(I_ARRAY_DATA) && $stable(tgl1_q);
  endproperty
  a_other_bank: assert property (p_other_bank) else $error("other bank read wrong");

  property p_prot_bound;
    @(posedge I_CLK) disable iff (I_RESET)
    (state_q == fwsr_pkg::ST_PROT_ERASE) |-> cnt_q < CNT_W'(fwsr_pkg::ASP_CYC);
  endproperty
  a_prot_bound: assert property (p_prot_bound) else $error("protected erase too long");

  property p_tmo_hold;
    @(posedge I_CLK) disable iff (I_RESET)
    (state_q == fwsr_pkg::ST_PROG && I_PULSE_LIMIT && !I_RESET_CMD)
      |=> (tmo_q && state_q == fwsr_pkg::ST_FAIL)
      ##1 ($past(I_RESET_CMD) || (tmo_q && state_q == fwsr_pkg::ST_FAIL));
  endproperty
  a_tmo_hold: assert property (p_tmo_hold) else $error("timeout flag lost");

  c_prog_done: cover property (@(posedge I_CLK) disable iff (I_RESET)
    state_q == fwsr_pkg::ST_PROG ##1 state_q == fwsr_pkg::ST_READ);
  c_suspend: cover property (@(posedge I_CLK) disable iff (I_RESET)
    state_q == fwsr_pkg::ST_ERASE ##1 state_q == fwsr_pkg::ST_SUSP);
  c_prot_erase: cover property (@(posedge I_CLK) disable iff (I_RESET)
    state_q == fwsr_pkg::ST_PROT_ERASE ##1 state_q == fwsr_pkg::ST_READ);

endmodule

// ---- rtl/fwsr_pkg.sv ----
// Shared constants and types for the flash write-status reporting block.
// Assumes a 100 ns system clock; all times below are turned into cycles here.
package fwsr_pkg;

  // Status bit positions in the data word
  localparam int BIT_POLL = 7;
  localparam int BIT_TGL1 = 6;
  localparam int BIT_TMO = 5;
  localparam int BIT_ERT = 3;
  localparam int BIT_TGL2 = 2;
  localparam int BIT_ABT = 1;

  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ERASED = 16'hFFFF;

  // Clock and protected-target status windows (plain defaults, in ns)
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_PSP_NS = 3000;
  localparam int T_PAP_NS = 3000;
  localparam int T_ASP_NS = 3000;

  // Least time rounds up, never below one cycle
  function automatic int ns_to_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PSP_CYC = ns_to_cycles(T_PSP_NS);
  localparam int PAP_CYC = ns_to_cycles(T_PAP_NS);
  localparam int ASP_CYC = ns_to_cycles(T_ASP_NS);

  typedef enum logic [2:0] {
    ST_READ,
    ST_PROG,
    ST_ERASE,
    ST_SUSP,
    ST_SUSP_PROG,
    ST_PROT_PROG,
    ST_PROT_ERASE,
    ST_FAIL
  } fwsr_state_t;

endpackage

// ---- rtl/fwsr_sync.sv ----
// Two-stage synchroniser for pin inputs.
// Assumes inputs are static bus levels; no multi-bit coherence is promised.
`timescale 1ns/1ps
module fwsr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule

// ---- testbench/fwsr_host_model.sv ----
// Host memory controller model: forms flash bus read cycles on the pins.
// Assumes the device passes pins through a two-stage synchroniser.
`timescale 1ns/1ps
module fwsr_host_model (
  // Clock
  input wire logic i_clk,
  // Flash bus pins
  output logic [23:0] o_addr,
  output logic o_address_valid_n,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  input wire logic [15:0] i_dq,
  input wire logic i_dq_oe
);
  initial begin
    o_addr = 24'h00_0000;
    o_address_valid_n = 1'b1;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    o_we_n = 1'b1;
  end

  // Every read is a fresh address-valid pulse, so the address is relatched
  task automatic rd(input logic [23:0] a, output logic [15:0] d, output logic oe);
    @(negedge i_clk);
    o_addr = a;
    o_address_valid_n = 1'b0;
    o_ce_n = 1'b0;
    o_oe_n = 1'b0;
    repeat (6) @(negedge i_clk);
    d = i_dq;
    oe = i_dq_oe;
    o_address_valid_n = 1'b1;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    // A released address must not keep its last value
    o_addr = ~a;
    repeat (3) @(negedge i_clk);
  endtask
endmodule

// ---- testbench/test_flash_write_status_reporting.sv ----
// Self-checking bench for the write-status reporting block.
// Assumes the array lookup answers within a cycle; modelled here by an assign.
`timescale 1ns/1ps
module test_flash_write_status_reporting;
  localparam int E_PROG = 0;
  localparam int E_ERASE = 1;
  localparam int E_DONE = 2;
  localparam int E_SUSP = 3;
  localparam int E_RES = 4;
  localparam int E_LIM = 5;
  localparam int E_ABT = 6;
  localparam int E_RCMD = 7;
  localparam logic [23:0] A_PRG = 24'h10_0010;
  localparam logic [23:0] A_SEL = 24'h20_0100;
  localparam logic [23:0] A_UNS = 24'h20_0000;
  localparam logic [23:0] A_SPG = 24'h30_0010;
  logic I_CLK = 1'b0;
  logic I_RESET = 1'b1;
  logic [23:0] addr;
  logic avd_n, ce_n, oe_n, we_n;
  logic [15:0] O_DQ;
  logic O_DQ_OE, O_BUSY;
  logic [7:0] ev = 8'h00;
  logic all_prot = 1'b0;
  logic begun = 1'b0;
  logic [23:0] op_addr = 24'h00_0000;
  logic [15:0] op_data = 16'h0000;
  logic [23:0] O_RD_ADDR;
  logic [15:0] arr;
  int bad_count = 0;
  int num_checks = 0;

  always #50 I_CLK = ~I_CLK;
  assign arr = {O_RD_ADDR[7:0], ~O_RD_ADDR[7:0]};

  fwsr_host_model u_fwsr_host_model (.i_clk(I_CLK), .o_addr(addr),
    .o_address_valid_n(avd_n), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .i_dq(O_DQ), .i_dq_oe(O_DQ_OE));

  fwsr_top u_fwsr_top (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(addr),
    .I_ADDRESS_VALID_N(avd_n), .I_CE_N(ce_n), .I_OE_N(oe_n), .I_WE_N(we_n),
    .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE), .O_BUSY(O_BUSY), .I_PROG_START(ev[E_PROG]),
    .I_ERASE_START(ev[E_ERASE]), .I_ALL_PROTECTED(all_prot), .I_OP_ADDR(op_addr),
    .I_OP_DATA(op_data), .I_OP_DONE(ev[E_DONE]), .I_SUSPEND(ev[E_SUSP]),
    .I_RESUME(ev[E_RES]), .I_PULSE_LIMIT(ev[E_LIM]), .I_BUF_ABORT(ev[E_ABT]),
    .I_RESET_CMD(ev[E_RCMD]), .I_ERASE_BEGUN(begun), .O_RD_ADDR(O_RD_ADDR),
    .I_ARRAY_DATA(arr), .I_SECTOR_SEL(O_RD_ADDR[8]));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input logic [15:0] m, input string msg);
    num_checks++;
    if ((got & m) !== (exp & m)) begin
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      bad_count++;
    end
  endtask

  task automatic kick(input int b);
    @(negedge I_CLK);
    ev[b] = 1'b1;
    @(negedge I_CLK);
    ev[b] = 1'b0;
  endtask

  // Bounded wait for the busy flag to drop
  task automatic wait_idle();
    int n;
    n = 0;
    while (O_BUSY !== 1'b0 && n < 100) begin
      @(negedge I_CLK);
      n++;
    end
    chk({15'h0000, O_BUSY}, 16'h0000, 16'h0001, "busy stuck");
    if (n >= 100) begin
      wrap_up();
    end
  endtask

  // n reads; last word vs exp, last two reads differ by tx on the toggle bits
  task automatic stat(input logic [23:0] a, input int n, input logic [15:0] exp,
                      input logic [15:0] m, input logic [15:0] tx, input logic [15:0] tm,
                      input logic bsy = 1'b1);
    logic [15:0] dp, d;
    logic oe;
    d = 16'h0000;
    for (int i = 0; i < n; i++) begin
      dp = d;
      u_fwsr_host_model.rd(a, d, oe);
    end
    chk(d, exp, m, "status word");
    chk(d ^ dp, tx, tm, "toggle pattern");
    chk({15'h0000, oe}, 16'h0001, 16'h0001, "output enable");
    chk({15'h0000, O_BUSY}, {15'h0000, bsy}, 16'h0001, "busy");
  endtask

  task automatic arr_rd(input logic [23:0] a);
    logic [15:0] d;
    logic oe;
    u_fwsr_host_model.rd(a, d, oe);
    chk(d, {a[7:0], ~a[7:0]}, 16'hFFFF, "array data");
  endtask

  task automatic t_reset();
    chk(O_DQ, 16'hFFFF, 16'hFFFF, "reset data");
    chk({14'h0000, O_BUSY, O_DQ_OE}, 16'h0000, 16'h0003, "reset flags");
  endtask

  task automatic t_program();
    op_addr = A_PRG;
    op_data = 16'h80A5;
    kick(E_PROG);
    stat(A_PRG, 3, 16'h0000, 16'hFFBB, 16'h0040, 16'h0044);
    arr_rd(24'h50_0040);
    kick(E_DONE);
    wait_idle();
    arr_rd(A_PRG);
  endtask

  task automatic t_erase();
    op_addr = A_UNS;
    begun = 1'b1;
    kick(E_ERASE);
    stat(A_SEL, 3, 16'h0008, 16'hFFBB, 16'h0044, 16'h0044);
    stat(A_UNS, 3, 16'h0008, 16'hFFBB, 16'h0040, 16'h0044);
    kick(E_SUSP);
    arr_rd(A_UNS);
    op_addr = A_SPG;
    op_data = 16'h0000;
    kick(E_PROG);
    stat(A_SPG, 3, 16'h0080, 16'hFFBB, 16'h0040, 16'h0044);
    kick(E_DONE);
    arr_rd(A_SPG);
    stat(A_SEL, 3, 16'h0080, 16'hFFB3, 16'h0004, 16'h0044, 1'b0);
    kick(E_RES);
    kick(E_DONE);
    wait_idle();
    arr_rd(A_SEL);
    begun = 1'b0;
  endtask

  // Protected targets: status for a bounded window, then array reads again
  task automatic t_protected();
    all_prot = 1'b1;
    op_addr = A_PRG;
    op_data = 16'h80A5;
    kick(E_PROG);
    stat(A_PRG, 2, 16'h0000, 16'hFFBB, 16'h0040, 16'h0040);
    wait_idle();
    arr_rd(A_PRG);
    op_addr = A_UNS;
    kick(E_ERASE);
    stat(A_SEL, 2, 16'h0000, 16'hFFB3, 16'h0040, 16'h0040);
    wait_idle();
    arr_rd(A_SEL);
    all_prot = 1'b0;
  endtask

  task automatic t_fail();
    op_addr = A_PRG;
    op_data = 16'h80A5;
    kick(E_PROG);
    // Flags latch only on the way into the failed state, so both land together
    @(negedge I_CLK);
    ev[E_LIM] = 1'b1;
    ev[E_ABT] = 1'b1;
    @(negedge I_CLK);
    ev[E_LIM] = 1'b0;
    ev[E_ABT] = 1'b0;
    stat(A_PRG, 3, 16'h0022, 16'hFFBB, 16'h0040, 16'h0040);
    kick(E_RCMD);
    wait_idle();
    arr_rd(A_PRG);
  endtask

  initial begin
    repeat (6) @(negedge I_CLK);
    t_reset();
    I_RESET = 1'b0;
    repeat (3) @(negedge I_CLK);
    t_program();
    t_erase();
    t_protected();
    t_fail();
    wrap_up();
  end
endmodule
